// file: core/cao_defines.svh
// Offsets, field positions, reset values and timing counts of the counter alarm block.
// Assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses.
`ifndef CAO_DEFINES_SVH
`define CAO_DEFINES_SVH
`define CAO_CTRL_IDX 10'h000
`define CAO_CH_FIRST 7'h01
`define CAO_R_CFG 3'h0
`define CAO_R_HI 3'h1
`define CAO_R_LO 3'h2
`define CAO_R_INIT 3'h3
`define CAO_R_COUNT 3'h4
`define CAO_R_OVF 3'h5
`define CAO_R_STAT 3'h6
`define CAO_CFG_HI_EN 0
`define CAO_CFG_LO_EN 1
`define CAO_CFG_HI_MAP 2
`define CAO_CFG_LO_MAP 3
`define CAO_CFG_HI_CLR 4
`define CAO_CFG_LO_CLR 5
`define CAO_CFG_HI_SLOT 8
`define CAO_CFG_HI_CHAN 12
`define CAO_CFG_LO_SLOT 16
`define CAO_CFG_LO_CHAN 20
`define CAO_CFG_MASK 32'h00FF_FF3F
`define CAO_RST_CFG 32'h0000_0000
`define CAO_RST_HI 32'hFFFF_FFFF
`define CAO_RST_LO 32'h0000_0000
`define CAO_RST_INIT 32'h0000_0000
`define CAO_RST_MODE 3'h0
`define CAO_CNT_MIN 32'h0000_0000
`define CAO_CNT_MAX 32'hFFFF_FFFF
`define CAO_RESP_OKAY 2'h0
`define CAO_RESP_SLVERR 2'h2
`define CAO_GATE_MS 1000
`define CAO_CLK_KHZ 200000
`define CAO_GATE_CYCLES (`CAO_GATE_MS * `CAO_CLK_KHZ)
`endif

// file: core/cao_pkg.sv
// Types shared by the counter alarm block.
// Assumes cao_defines.svh holds the numbers.
package cao_pkg;
   typedef enum logic [2:0] {
      cao_mode_updown,
      cao_mode_bidir,
      cao_mode_up,
      cao_mode_quad,
      cao_mode_freq
   } cao_mode_type;
endpackage : cao_pkg

// file: core/cao_chan_if.sv
// Carrier between the register top and one counting channel.
// Assumes both ends share aclk.
`timescale 1ns/100ps
interface cao_chan_if;
   import cao_pkg::*;
   cao_mode_type mode;
   logic gate_tick;
   logic load;
   logic [1:0] in_ab;
   logic [31:0] init_value;
   logic [31:0] hi_limit;
   logic [31:0] lo_limit;
   logic hi_en;
   logic lo_en;
   logic hi_clr;
   logic lo_clr;
   logic [31:0] count;
   logic signed [31:0] ovf;
   logic hi_latched;
   logic lo_latched;
   modport ctrl (output mode, gate_tick, load, in_ab, init_value, hi_limit, lo_limit,
      hi_en, lo_en, hi_clr, lo_clr, input count, ovf, hi_latched, lo_latched);
   modport chan (input mode, gate_tick, load, in_ab, init_value, hi_limit, lo_limit,
      hi_en, lo_en, hi_clr, lo_clr, output count, ovf, hi_latched, lo_latched);
endinterface : cao_chan_if

// file: core/cao_channel.sv
// One counting channel: count, overflow tally, frequency capture and alarm latches.
// Assumes field inputs are already synchronous to aclk.
`timescale 1ns/100ps
`include "cao_defines.svh"
module cao_channel
   import cao_pkg::*;
(
   input logic aclk,
   input logic aresetn,
   cao_chan_if.chan bus
);
   logic [1:0] ab_prev_q;
   logic [31:0] count_q;
   logic signed [31:0] ovf_q;
   logic [31:0] freq_q;
   logic hi_q;
   logic lo_q;
   logic rise_a;
   logic rise_b;
   logic step_up;
   logic step_dn;
   logic quad_chg;
   logic quad_dir;

   assign rise_a = bus.in_ab[0] & ~ab_prev_q[0];
   assign rise_b = bus.in_ab[1] & ~ab_prev_q[1];
   // Both phases moving at once is an illegal quadrature step and is dropped
   assign quad_chg = (bus.in_ab[0] ^ ab_prev_q[0]) ^ (bus.in_ab[1] ^ ab_prev_q[1]);
   assign quad_dir = bus.in_ab[0] ^ ab_prev_q[1];

   always_comb
   begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case (bus.mode)
         cao_mode_updown:
         begin
            step_up = rise_a & ~rise_b;
            step_dn = rise_b & ~rise_a;
         end
         cao_mode_bidir:
         begin
            step_up = rise_a & bus.in_ab[1];
            step_dn = rise_a & ~bus.in_ab[1];
         end
         cao_mode_up: step_up = rise_a;
         cao_mode_quad:
         begin
            step_up = quad_chg & quad_dir;
            step_dn = quad_chg & ~quad_dir;
         end
         default:
         begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ab_prev_q <= 2'h0;
      else
         ab_prev_q <= bus.in_ab;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_q <= `CAO_RST_INIT;
         ovf_q <= 32'sh0;
         freq_q <= 32'h0;
      end
      else if (bus.load)
      begin
         count_q <= bus.init_value;
         ovf_q <= 32'sh0;
         freq_q <= 32'h0;
      end
      else if (bus.mode == cao_mode_freq)
      begin
         // Edges per one-second gate give hertz directly
         if (bus.gate_tick)
         begin
            count_q <= freq_q + {31'h0, rise_a};
            freq_q <= 32'h0;
         end
         else
            freq_q <= freq_q + {31'h0, rise_a};
      end
      else if (step_up)
      begin
         if (count_q == `CAO_CNT_MAX)
         begin
            ovf_q <= ovf_q + 32'sh1;
            count_q <= bus.init_value;
         end
         else
            count_q <= count_q + 32'h1;
      end
      else if (step_dn)
      begin
         if (count_q == `CAO_CNT_MIN)
         begin
            ovf_q <= ovf_q - 32'sh1;
            count_q <= bus.init_value;
         end
         else
            count_q <= count_q - 32'h1;
      end
   end

   // A clear only releases the latch once the trip condition has gone away
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hi_q <= 1'b0;
         lo_q <= 1'b0;
      end
      else
      begin
         hi_q <= bus.hi_en & ((count_q > bus.hi_limit) | (hi_q & ~bus.hi_clr));
         lo_q <= bus.lo_en & ((count_q < bus.lo_limit) | (lo_q & ~bus.lo_clr));
      end
   end

   assign bus.count = count_q;
   assign bus.ovf = ovf_q;
   assign bus.hi_latched = hi_q;
   assign bus.lo_latched = lo_q;
endmodule : cao_channel

// file: core/cao_counter_alarm.sv
// Multi-channel pulse counter with overflow tally, latched alarms and output mapping.
// Assumes an AXI4-Lite master on aclk and field inputs synchronous to aclk.
// What this block does
// - Count passing the maximum adds one to the channel's signed overflow tally.
// - Count falling below the minimum takes one from the overflow tally.
// - Past either limit the count restarts from the initial value, no wrap.
// - The overflow tally is readable by software.
// - Count limits are fixed: zero and the full unsigned 32-bit value.
// - High alarm state is either latching or disabled.
// - High alarm limit spans the whole unsigned 32-bit range.
// - An output mode bit enables forwarding the alarm to a digital output.
// - A slot field selects which digital output module receives the alarm.
// - A channel field selects the output channel within that module.
// - Setting the clear bit releases a latched alarm back to normal.
// - The clear bit drops back to disabled once the alarm is normal.
// - Modes: up/down, bidirectional, up only, quadrature and frequency.
// - Frequency mode measures 5 Hz to 1 MHz; counting accepts 1 MHz.
// - One mode applies to all channels together.
// - Simultaneous up and down pulses leave the count unchanged.
`timescale 1ns/100ps
`include "cao_defines.svh"
module cao_counter_alarm
   import cao_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int SLOTS = 8,
   parameter int DO_CH = 16,
   parameter int GATE_CYCLES = `CAO_GATE_CYCLES
)
(
   input logic aclk,
   input logic aresetn,
   input logic [11:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [11:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [NUM_CH-1:0] cnt_in_a,
   input logic [NUM_CH-1:0] cnt_in_b,
   output logic [SLOTS*DO_CH-1:0] alarm_do
);
   logic [11:0] aw_addr_q;
   logic aw_full_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_full_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic do_write;
   logic wr_ok;
   logic rd_ok;
   logic [31:0] rd_data;
   logic [2:0] mode_q;
   logic [31:0] cfg_q [NUM_CH];
   logic [31:0] hi_lim_q [NUM_CH];
   logic [31:0] lo_lim_q [NUM_CH];
   logic [31:0] init_q [NUM_CH];
   logic [NUM_CH-1:0] load_q;
   logic [31:0] count_w [NUM_CH];
   logic [31:0] ovf_w [NUM_CH];
   logic [NUM_CH-1:0] hi_lat_w;
   logic [NUM_CH-1:0] lo_lat_w;
   logic [31:0] gate_cnt_q;
   logic gate_tick_q;
   logic [SLOTS*DO_CH-1:0] do_d;
   logic [SLOTS*DO_CH-1:0] do_q;

   function automatic logic cao_ch_hit(input logic [11:0] a);
      cao_ch_hit = (a[11:5] >= `CAO_CH_FIRST) && (int'(a[11:5]) <= NUM_CH)
         && (a[4:2] <= `CAO_R_STAT);
   endfunction : cao_ch_hit

   function automatic logic [31:0] cao_merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = wd[i*8 +: 8];
      end
      cao_merge = res;
   endfunction : cao_merge

   // Write path: address and data are held independently until both are in
   assign do_write = aw_full_q & w_full_q & ~bvalid_q;
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign wr_ok = (aw_addr_q[11:2] == `CAO_CTRL_IDX) || (cao_ch_hit(aw_addr_q)
      && (aw_addr_q[4:2] <= `CAO_R_INIT));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end
      else if (s_axi_awvalid && !aw_full_q)
      begin
         aw_full_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
         aw_full_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_full_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else if (s_axi_wvalid && !w_full_q)
      begin
         w_full_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end
      else if (do_write)
         w_full_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= `CAO_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? `CAO_RESP_OKAY : `CAO_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // Read path: one read in flight, data registered at the address handshake
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_comb
   begin
      int ci;
      ci = int'(s_axi_araddr[11:5]) - 1;
      rd_ok = 1'b0;
      rd_data = 32'h0000_0000;
      if (s_axi_araddr[11:2] == `CAO_CTRL_IDX)
      begin
         rd_ok = 1'b1;
         rd_data = {29'h0, mode_q};
      end
      else if (cao_ch_hit(s_axi_araddr))
      begin
         rd_ok = 1'b1;
         case (s_axi_araddr[4:2])
            `CAO_R_CFG: rd_data = cfg_q[ci];
            `CAO_R_HI: rd_data = hi_lim_q[ci];
            `CAO_R_LO: rd_data = lo_lim_q[ci];
            `CAO_R_INIT: rd_data = init_q[ci];
            `CAO_R_COUNT: rd_data = count_w[ci];
            `CAO_R_OVF: rd_data = ovf_w[ci];
            `CAO_R_STAT: rd_data = {30'h0, lo_lat_w[ci], hi_lat_w[ci]};
            default: rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q <= `CAO_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_ok ? `CAO_RESP_OKAY : `CAO_RESP_SLVERR;
         rdata_q <= rd_data;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // One mode register steers every channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_q <= `CAO_RST_MODE;
      else if (do_write && aw_addr_q[11:2] == `CAO_CTRL_IDX && w_strb_q[0])
         mode_q <= w_data_q[2:0];
   end

   // Frequency gate shared by all channels so their readings line up
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gate_cnt_q <= 32'h0000_0000;
         gate_tick_q <= 1'b0;
      end
      else if (gate_cnt_q == 32'(GATE_CYCLES - 1))
      begin
         gate_cnt_q <= 32'h0000_0000;
         gate_tick_q <= 1'b1;
      end
      else
      begin
         gate_cnt_q <= gate_cnt_q + 32'h1;
         gate_tick_q <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         logic ch_wr;
         cao_chan_if ch_if ();
         assign ch_wr = do_write && cao_ch_hit(aw_addr_q) && (int'(aw_addr_q[11:5]) == g + 1);

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               cfg_q[g] <= `CAO_RST_CFG;
            else if (ch_wr && aw_addr_q[4:2] == `CAO_R_CFG)
               cfg_q[g] <= cao_merge(cfg_q[g], w_data_q, w_strb_q) & `CAO_CFG_MASK;
            else
            begin
               // The clear bit falls back by itself once the latch has let go
               if (cfg_q[g][`CAO_CFG_HI_CLR] && !hi_lat_w[g])
                  cfg_q[g][`CAO_CFG_HI_CLR] <= 1'b0;
               if (cfg_q[g][`CAO_CFG_LO_CLR] && !lo_lat_w[g])
                  cfg_q[g][`CAO_CFG_LO_CLR] <= 1'b0;
            end
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               hi_lim_q[g] <= `CAO_RST_HI;
               lo_lim_q[g] <= `CAO_RST_LO;
               init_q[g] <= `CAO_RST_INIT;
               load_q[g] <= 1'b0;
            end
            else
            begin
               load_q[g] <= ch_wr && (aw_addr_q[4:2] == `CAO_R_INIT);
               if (ch_wr && aw_addr_q[4:2] == `CAO_R_HI)
                  hi_lim_q[g] <= cao_merge(hi_lim_q[g], w_data_q, w_strb_q);
               if (ch_wr && aw_addr_q[4:2] == `CAO_R_LO)
                  lo_lim_q[g] <= cao_merge(lo_lim_q[g], w_data_q, w_strb_q);
               if (ch_wr && aw_addr_q[4:2] == `CAO_R_INIT)
                  init_q[g] <= cao_merge(init_q[g], w_data_q, w_strb_q);
            end
         end

         assign ch_if.mode = cao_mode_type'(mode_q);
         assign ch_if.gate_tick = gate_tick_q;
         assign ch_if.load = load_q[g];
         assign ch_if.in_ab = {cnt_in_b[g], cnt_in_a[g]};
         assign ch_if.init_value = init_q[g];
         assign ch_if.hi_limit = hi_lim_q[g];
         assign ch_if.lo_limit = lo_lim_q[g];
         assign ch_if.hi_en = cfg_q[g][`CAO_CFG_HI_EN];
         assign ch_if.lo_en = cfg_q[g][`CAO_CFG_LO_EN];
         assign ch_if.hi_clr = cfg_q[g][`CAO_CFG_HI_CLR];
         assign ch_if.lo_clr = cfg_q[g][`CAO_CFG_LO_CLR];
         assign count_w[g] = ch_if.count;
         assign ovf_w[g] = ch_if.ovf;
         assign hi_lat_w[g] = ch_if.hi_latched;
         assign lo_lat_w[g] = ch_if.lo_latched;

         cao_channel u_chan (
            .aclk (aclk),
            .aresetn (aresetn),
            .bus (ch_if.chan)
         );
      end
   endgenerate

   // Output map: a slot or channel beyond the fitted range drives nothing
   always_comb
   begin
      int hs;
      int hc;
      int ls;
      int lc;
      hs = 0;
      hc = 0;
      ls = 0;
      lc = 0;
      do_d = '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         hs = int'(cfg_q[c][`CAO_CFG_HI_SLOT +: 3]);
         hc = int'(cfg_q[c][`CAO_CFG_HI_CHAN +: 4]);
         ls = int'(cfg_q[c][`CAO_CFG_LO_SLOT +: 3]);
         lc = int'(cfg_q[c][`CAO_CFG_LO_CHAN +: 4]);
         if (hi_lat_w[c] && cfg_q[c][`CAO_CFG_HI_MAP] && hs < SLOTS && hc < DO_CH)
            do_d[hs*DO_CH + hc] = 1'b1;
         if (lo_lat_w[c] && cfg_q[c][`CAO_CFG_LO_MAP] && ls < SLOTS && lc < DO_CH)
            do_d[ls*DO_CH + lc] = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         do_q <= '0;
      else
         do_q <= do_d;
   end

   assign alarm_do = do_q;
endmodule : cao_counter_alarm

// file: dv/cao_counter_alarm_properties.sv
// Register bus properties of the counter alarm block, bound to its top module.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/100ps
module cao_counter_alarm_properties
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_bvalid_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response changed before it was taken");
   a_rvalid_holds:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
         && $stable(s_axi_rresp))
      else $error("Read answer changed before it was taken");
   a_ar_blocked:
      assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("Read address accepted while an answer is pending");
   a_read_prompt:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("Write response not two cycles after the write was taken");
   a_aw_held:
      assert property (s_axi_awvalid && s_axi_awready && !s_axi_wvalid |=> !s_axi_awready)
      else $error("Second address accepted while one is held");
   a_bresp_legal:
      assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
      else $error("Illegal write response code");
   a_unmapped_read:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hFFC
         |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("Unmapped read not refused");
   a_ro_write_err:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         && !s_axi_bvalid && s_axi_awaddr == 12'h030 |=> ##1 s_axi_bvalid && s_axi_bresp == 2'h2)
      else $error("Write to a read-only count not refused");
endmodule : cao_counter_alarm_properties
bind cao_counter_alarm cao_counter_alarm_properties u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: dv/cao_pulse_src.sv
// Field pulse source model for the four counter channels.
// Assumes its tasks are called right after a rising aclk edge.
`timescale 1ns/100ps
module cao_pulse_src
(
   input wire logic aclk,
   output logic [3:0] cnt_in_a,
   output logic [3:0] cnt_in_b
);
   logic [3:0] dir_q = 4'h0;
   initial cnt_in_a = 4'h0;
   initial cnt_in_b = 4'h0;
   // A returns low and B returns to its direction level after one cycle, so every pulse is a fresh rising edge
   task automatic pulse(input logic [3:0] ma, input logic [3:0] mb);
      @(posedge aclk);
      cnt_in_a <= ma;
      cnt_in_b <= mb | dir_q;
      @(posedge aclk);
      cnt_in_a <= 4'h0;
      cnt_in_b <= dir_q;
   endtask : pulse
   // Direction is a level, held between pulses
   task automatic set_dir(input logic [3:0] d);
      @(posedge aclk);
      dir_q <= d;
      cnt_in_b <= d;
   endtask : set_dir
   // Plain levels for phase patterns, held until the next call
   task automatic drive(input logic [3:0] la, input logic [3:0] lb);
      @(posedge aclk);
      cnt_in_a <= la;
      cnt_in_b <= lb;
   endtask : drive
endmodule : cao_pulse_src

// file: dv/cao_tb.sv
// Self-checking bench: register bus, counting modes, overflow tally and alarms.
// Assumes the pulse source model on the field inputs and one 200 MHz clock.
`timescale 1ns/100ps
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [3:0] cnt_in_a, cnt_in_b, m;
   logic [127:0] alarm_do;
   logic [31:0] rst_tab [7] = '{32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] hv [3] = '{32'h0, 32'hFFFFFFFF, 32'h0};
   logic [31:0] init_r [4];
   int n_r [4];
   logic [31:0] v_cur;
   logic [127:0] v_tot;
   int failures = 0, checks = 0, seed = 32'h1C716CAC;
   always #2.5 aclk = ~aclk;
   // Short gate keeps frequency mode cheap to run
   cao_counter_alarm #(.GATE_CYCLES(50)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cnt_in_a(cnt_in_a), .cnt_in_b(cnt_in_b), .alarm_do(alarm_do));
   cao_pulse_src src (.aclk(aclk), .cnt_in_a(cnt_in_a), .cnt_in_b(cnt_in_b));
   task automatic test_done;
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (bvalid) break;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         bready <= 1'b1;
      end
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (rvalid) break;
         if (arvalid && arready) arvalid <= 1'b0;
         rready <= 1'b1;
      end
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", er, rresp);
   endtask : rd
   function automatic logic [11:0] ra(input int ch, input int off);
      return 12'(32'h20 + ch * 32'h20 + off);
   endfunction : ra
   function automatic logic [127:0] do_bit(input int slot, input int chan);
      return 128'h1 << (slot * 16 + chan);
   endfunction : do_bit
   // Host-side total of pulses seen, from initial value, overflow tally and current count
   function automatic logic [127:0] totalizer_value(input logic [31:0] ini,
      input logic [31:0] lim, input logic signed [31:0] ovf, input logic [31:0] cur);
      return (128'((ini > lim) ? ini - lim : lim - ini) + 128'h1)
         * 128'((ovf < 0) ? -ovf : ovf) + 128'((ini > cur) ? ini - cur : cur - ini);
   endfunction : totalizer_value
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 7; i++)
         rd(ra(0, 4 * i), rst_tab[i], 2'h0);
      rd(12'hFFC, 32'h0, 2'h2);
      wr(ra(0, 16), 32'h1, 2'h2);
      for (int k = 4; k >= 0; k--)
      begin
         wr(12'h000, 32'(k), 2'h0);
         rd(12'h000, 32'(k), 2'h0);
      end
      wr(ra(0, 12), 32'hFFFFFFFE, 2'h0);
      wr(ra(1, 12), 32'h1, 2'h0);
      wr(ra(2, 12), 32'h64, 2'h0);
      repeat (2) src.pulse(4'h5, 4'h6);
      repeat (3) @(posedge aclk);
      rd(ra(0, 16), 32'hFFFFFFFE, 2'h0);
      v_cur = rdata;
      rd(ra(0, 20), 32'h1, 2'h0);
      v_tot = totalizer_value(32'hFFFFFFFE, 32'hFFFFFFFF, rdata, v_cur);
      chk("totalizer_value", 128'h2, v_tot);
      rd(ra(1, 16), 32'h1, 2'h0);
      v_cur = rdata;
      rd(ra(1, 20), 32'hFFFFFFFF, 2'h0);
      v_tot = totalizer_value(32'h1, 32'h0, rdata, v_cur);
      chk("totalizer_value", 128'h2, v_tot);
      rd(ra(2, 16), 32'h64, 2'h0);
      hv[2] = $random(seed);
      for (int i = 0; i < 3; i++)
      begin
         wr(ra(3, 4), hv[i], 2'h0);
         rd(ra(3, 4), hv[i], 2'h0);
      end
      // High alarm on slot 2 channel 3, then a clear while the count is back in range
      wr(ra(0, 4), 32'h6, 2'h0);
      wr(ra(0, 12), 32'h5, 2'h0);
      wr(ra(0, 0), 32'h3205, 2'h0);
      repeat (2) src.pulse(4'h1, 4'h0);
      repeat (3) @(posedge aclk);
      rd(ra(0, 24), 32'h1, 2'h0);
      chk("alarm_do", do_bit(2, 3), alarm_do);
      wr(ra(0, 12), 32'h5, 2'h0);
      rd(ra(0, 24), 32'h1, 2'h0);
      chk("alarm_do", do_bit(2, 3), alarm_do);
      wr(ra(0, 0), 32'h3215, 2'h0);
      repeat (3) @(posedge aclk);
      rd(ra(0, 24), 32'h0, 2'h0);
      rd(ra(0, 0), 32'h3205, 2'h0);
      chk("alarm_do", 128'h0, alarm_do);
      wr(ra(0, 0), 32'h3201, 2'h0);
      repeat (2) src.pulse(4'h1, 4'h0);
      repeat (3) @(posedge aclk);
      rd(ra(0, 24), 32'h1, 2'h0);
      chk("alarm_do", 128'h0, alarm_do);
      wr(ra(0, 0), 32'h0, 2'h0);
      rd(ra(0, 24), 32'h0, 2'h0);
      // Low alarm mirrors the high one, mapped to slot 1 channel 0
      wr(ra(1, 8), 32'h5, 2'h0);
      wr(ra(1, 12), 32'h5, 2'h0);
      wr(ra(1, 0), 32'h1000A, 2'h0);
      src.pulse(4'h0, 4'h2);
      repeat (3) @(posedge aclk);
      rd(ra(1, 24), 32'h2, 2'h0);
      chk("alarm_do", do_bit(1, 0), alarm_do);
      wr(ra(1, 0), 32'h0, 2'h0);
      repeat (3) @(posedge aclk);
      chk("alarm_do", 128'h0, alarm_do);
      // Up only on all channels at once, random counts; pulses on B must be ignored
      wr(12'h000, 32'h2, 2'h0);
      for (int c = 0; c < 4; c++)
      begin
         init_r[c] = {16'h0, 16'($random(seed))};
         n_r[c] = $unsigned($random(seed)) % 8;
         wr(ra(c, 12), init_r[c], 2'h0);
      end
      for (int k = 0; k < 8; k++)
      begin
         for (int c = 0; c < 4; c++)
            m[c] = (k < n_r[c]);
         src.pulse(m, 4'($random(seed)));
      end
      repeat (3) @(posedge aclk);
      for (int c = 0; c < 4; c++)
         rd(ra(c, 16), init_r[c] + 32'(n_r[c]), 2'h0);
      // Direction level: channels 0 and 1 up, 2 and 3 down
      wr(12'h000, 32'h1, 2'h0);
      for (int c = 0; c < 4; c++)
         wr(ra(c, 12), 32'h64, 2'h0);
      src.set_dir(4'h3);
      src.pulse(4'hF, 4'h0);
      repeat (3) @(posedge aclk);
      for (int c = 0; c < 4; c++)
         rd(ra(c, 16), (c < 2) ? 32'h65 : 32'h63, 2'h0);
      // Quadrature: one full forward cycle on channels 0 and 1 is four steps up
      wr(12'h000, 32'h3, 2'h0);
      src.drive(4'h0, 4'h0);
      src.drive(4'h3, 4'h0);
      src.drive(4'h3, 4'h3);
      src.drive(4'h0, 4'h3);
      repeat (3) @(posedge aclk);
      for (int c = 0; c < 4; c++)
         rd(ra(c, 16), (c < 2) ? 32'h69 : 32'h63, 2'h0);
      // Pulses every second cycle give 25 edges in each 50-cycle gate
      wr(12'h000, 32'h4, 2'h0);
      fork
         repeat (100) src.pulse(4'h1, 4'h0);
         begin
            repeat (150) @(posedge aclk);
            rd(ra(0, 16), 32'h19, 2'h0);
         end
      join
      test_done;
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      failures++;
      test_done;
   end
endmodule : tb
